/* File: logic/ups_pkg.sv */
// Constants, types and helpers for the serial port power-save controller
//
// Behaviour
// - Selecting setting 1 disables the port at once, ignoring the inactivity timeout.
// - Setting 1 holds the port on until 40..65000 frames of inactivity (default 2000).
// - Each received character while active restarts the inactivity timer.
// - Pending outgoing data enables the port and blocks idle.
// - Setting 1 on 2G: enable at paging, then off until first paging after 2.0 s.
// - Setting 1 on 3G: enabled about 20 ms, then disabled 2.5 s, repeating.
// - Setting 1 unregistered: about 20 ms enabled, 2.5 s disabled, repeating.
// - With flow control on, clear-to-send low while enabled, high while disabled.
// - Setting 2 is accepted only with hardware flow control off.
// - Setting 2: request-to-send OFF disables the port unless data is pending.
// - Setting 2: request-to-send rising enables the port; active after about 20 ms.
// - Setting 2: request-to-send ON keeps the port enabled and blocks idle.
// - Setting 3 allowed with any flow control; with flow control on, clear-to-send follows port enable.
// - Setting 3: terminal-ready OFF disables the port unless data is pending.
// - Setting 3: terminal-ready rising enables the port; active after 20 ms.
// - Setting 3: terminal-ready ON keeps the port enabled and blocks idle.
// - Rising received data while disabled wakes within 20 ms; first character discarded.
// - Wake on received data is armed only in setting 1 with flow control off.
// - Setting 2 with RTS OFF or setting 3 with DTR OFF discards input.
// - A connected, unsuspended USB link forces active mode; port follows the setting.
// - Setting 0 after reset: port enabled, never idle, clear-to-send held ON.
package ups_pkg;

   // ******************************
   // Register bus
   // ******************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] REG_TIMEOUT = 8'h04;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
   localparam int CTRL_SET_LSB = 0;
   localparam int CTRL_FLOW_BIT = 2;
   localparam int STAT_PORT_BIT = 0;
   localparam int STAT_ACTIVE_BIT = 1;
   localparam int STAT_REJECT_BIT = 2;
   localparam int STAT_WAKE_BIT = 3;
   localparam int STAT_STATE_LSB = 4;

   // ******************************
   // Settings and network codes
   // ******************************
   localparam logic [1:0] PS_ALWAYS = 2'h0;
   localparam logic [1:0] PS_CYCLIC = 2'h1;
   localparam logic [1:0] PS_RTS = 2'h2;
   localparam logic [1:0] PS_DTR = 2'h3;
   localparam logic [1:0] NET_NONE = 2'h0;
   localparam logic [1:0] NET_2G = 2'h1;
   localparam logic [1:0] NET_3G = 2'h2;

   // ******************************
   // Reset values
   // ******************************
   localparam logic [1:0] RST_SETTING = PS_ALWAYS;
   localparam logic RST_FLOW = 1'b1;
   localparam logic [15:0] TMO_MIN = 16'h0028;
   localparam logic [15:0] TMO_MAX = 16'hFDE8;
   localparam logic [15:0] TMO_DEFAULT = 16'h07D0;

   // ******************************
   // Timing
   // ******************************
   localparam int TMR_W = 32;
   localparam int CLK_HZ = 10000000;
   localparam int WAKE_TIME_MS = 20;
   localparam int SLEEP_2G_MS = 2000;
   localparam int SLEEP_3G_MS = 2500;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   localparam logic [TMR_W-1:0] WAKE_CYCLES = TMR_W'(WAKE_TIME_MS * CYC_PER_MS);
   localparam logic [TMR_W-1:0] SLEEP_2G_CYCLES =
      TMR_W'(SLEEP_2G_MS * CYC_PER_MS);
   localparam logic [TMR_W-1:0] SLEEP_3G_CYCLES =
      TMR_W'(SLEEP_3G_MS * CYC_PER_MS);

   typedef enum logic [1:0] {ST_DISABLED, ST_WAIT_PAGE, ST_WINDOW}
      ups_state_type;

   // Keeps a programmed timeout inside its legal frame range
   function automatic logic [15:0] clampTimeout(input logic [15:0] v);
      if (v < TMO_MIN) begin
         return TMO_MIN;
      end else if (v > TMO_MAX) begin
         return TMO_MAX;
      end
      return v;
   endfunction : clampTimeout

endpackage : ups_pkg

/* File: logic/ups_timer_if.sv */
// Load and status signals of one cycle down-counter
interface ups_timer_if;
   logic load;
   logic [ups_pkg::TMR_W-1:0] loadValue;
   logic busy;
   logic done;
   modport owner(output load, output loadValue, input busy, input done);
   modport timer(input load, input loadValue, output busy, output done);
endinterface : ups_timer_if

/* File: logic/ups_cycle_timer.sv */
// Loadable down-counter with busy level and done pulse
module ups_cycle_timer (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Control
   ups_timer_if.timer tmr
);
   import ups_pkg::*;

   logic [TMR_W-1:0] count_ff;
   logic [TMR_W-1:0] nxt_count;
   logic done_ff;
   logic nxt_done;

   always_comb begin
      nxt_count = count_ff;
      nxt_done = 1'b0;
      if (tmr.load) begin
         nxt_count = tmr.loadValue;
      end else if (count_ff != '0) begin
         nxt_count = count_ff - TMR_W'(1);
         nxt_done = (count_ff == TMR_W'(1));
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         count_ff <= '0;
         done_ff <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         done_ff <= nxt_done;
      end
   end

   assign tmr.busy = (count_ff != '0);
   assign tmr.done = done_ff;

endmodule : ups_cycle_timer

/* File: logic/ups_power_save.sv */
// Serial port enable and idle control for the four power-save settings
//
// Our own choices: the strobed register port and the address map.
module ups_power_save #(
   parameter logic [ups_pkg::TMR_W-1:0] WAKE_CYC = ups_pkg::WAKE_CYCLES,
   parameter logic [ups_pkg::TMR_W-1:0] SLEEP_2G_CYC = ups_pkg::SLEEP_2G_CYCLES,
   parameter logic [ups_pkg::TMR_W-1:0] SLEEP_3G_CYC = ups_pkg::SLEEP_3G_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Register port
   input wire logic [ups_pkg::ADDR_W-1:0] regAddr,
   input wire logic [ups_pkg::DATA_W-1:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [ups_pkg::DATA_W-1:0] regRdata,
   // Radio and system events
   input wire logic frameTick,
   input wire logic pagingStrobe,
   input wire logic [1:0] netState,
   input wire logic usbActive,
   // Serial core
   input wire logic txPending,
   input wire logic rxCharStrobe,
   output logic portEnable,
   output logic rxDiscard,
   output logic activeMode,
   // Serial pins
   input wire logic rxdPin,
   input wire logic rtsPin_n,
   input wire logic dtrPin_n,
   output logic ctsPin_n
);
   import ups_pkg::*;

   // ******************************
   // Timers
   // ******************************
   ups_timer_if wakeTmr();
   ups_timer_if sleepTmr();

   ups_cycle_timer u_wake (
      .core_clk(core_clk),
      .rst(rst),
      .tmr(wakeTmr.timer)
   );

   ups_cycle_timer u_sleep (
      .core_clk(core_clk),
      .rst(rst),
      .tmr(sleepTmr.timer)
   );

   // ******************************
   // Pin synchronisers
   // ******************************
   logic [2:0] pinMeta_ff;
   logic [2:0] pinSync_ff;
   logic [2:0] pinPrev_ff;
   logic [2:0] nxt_pinMeta;
   logic [2:0] nxt_pinSync;
   logic [2:0] nxt_pinPrev;

   always_comb begin
      nxt_pinMeta = {rxdPin, rtsPin_n, dtrPin_n};
      nxt_pinSync = pinMeta_ff;
      nxt_pinPrev = pinSync_ff;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pinMeta_ff <= 3'h7;
         pinSync_ff <= 3'h7;
         pinPrev_ff <= 3'h7;
      end else begin
         pinMeta_ff <= nxt_pinMeta;
         pinSync_ff <= nxt_pinSync;
         pinPrev_ff <= nxt_pinPrev;
      end
   end

   logic rtsOn;
   logic dtrOn;
   logic rtsRise;
   logic dtrRise;
   logic rxdRise;
   assign rtsOn = ~pinSync_ff[1];
   assign dtrOn = ~pinSync_ff[0];
   assign rtsRise = rtsOn & pinPrev_ff[1];
   assign dtrRise = dtrOn & pinPrev_ff[0];
   assign rxdRise = pinSync_ff[2] & ~pinPrev_ff[2];

   // ******************************
   // Configuration registers
   // ******************************
   logic [1:0] setting_ff;
   logic [1:0] nxt_setting;
   logic hwFlow_ff;
   logic nxt_hwFlow;
   logic [15:0] timeout_ff;
   logic [15:0] nxt_timeout;
   logic reject_ff;
   logic nxt_reject;
   logic cfgAccept;
   logic [1:0] wrSetting;
   logic wrFlow;

   assign wrSetting = regWdata[CTRL_SET_LSB +: 2];
   assign wrFlow = regWdata[CTRL_FLOW_BIT];

   always_comb begin
      nxt_setting = setting_ff;
      nxt_hwFlow = hwFlow_ff;
      nxt_timeout = timeout_ff;
      nxt_reject = reject_ff;
      cfgAccept = 1'b0;
      if (regWrite && regAddr == REG_STATUS && regWdata[STAT_REJECT_BIT]) begin
         nxt_reject = 1'b0;
      end
      if (regWrite && regAddr == REG_CTRL) begin
         if (wrSetting == PS_RTS && wrFlow) begin
            nxt_reject = 1'b1;
         end else begin
            cfgAccept = 1'b1;
            nxt_setting = wrSetting;
            nxt_hwFlow = wrFlow;
         end
      end
      if (regWrite && regAddr == REG_TIMEOUT) begin
         nxt_timeout = clampTimeout(regWdata[15:0]);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         setting_ff <= RST_SETTING;
         hwFlow_ff <= RST_FLOW;
         timeout_ff <= TMO_DEFAULT;
         reject_ff <= 1'b0;
      end else begin
         setting_ff <= nxt_setting;
         hwFlow_ff <= nxt_hwFlow;
         timeout_ff <= nxt_timeout;
         reject_ff <= nxt_reject;
      end
   end

   // ******************************
   // Cyclic enable sequencer
   // ******************************
   ups_state_type state_ff;
   ups_state_type nxt_state;
   logic [15:0] inact_ff;
   logic [15:0] nxt_inact;
   logic dataWake_ff;
   logic nxt_dataWake;
   logic isCyclic;
   logic wakeArmed;
   logic [TMR_W-1:0] sleepLen;

   assign isCyclic = (setting_ff == PS_CYCLIC);
   assign wakeArmed = isCyclic & ~hwFlow_ff;
   assign sleepLen = (netState == NET_2G) ? SLEEP_2G_CYC : SLEEP_3G_CYC;

   always_comb begin
      nxt_state = state_ff;
      nxt_inact = inact_ff;
      nxt_dataWake = dataWake_ff & wakeTmr.busy;
      wakeTmr.load = 1'b0;
      wakeTmr.loadValue = WAKE_CYC;
      sleepTmr.load = 1'b0;
      sleepTmr.loadValue = sleepLen;
      if (state_ff == ST_WINDOW && frameTick && inact_ff != 16'h0000) begin
         nxt_inact = inact_ff - 16'h0001;
      end
      if (cfgAccept) begin
         nxt_state = ST_DISABLED;
         nxt_inact = 16'h0000;
         nxt_dataWake = 1'b0;
         sleepTmr.load = (nxt_setting == PS_CYCLIC);
      end else if (isCyclic) begin
         case (state_ff)
            ST_DISABLED: begin
               if (wakeArmed && rxdRise) begin
                  nxt_state = ST_WINDOW;
                  nxt_inact = timeout_ff;
                  nxt_dataWake = 1'b1;
                  wakeTmr.load = 1'b1;
               end else if (sleepTmr.done) begin
                  if (netState == NET_2G) begin
                     nxt_state = ST_WAIT_PAGE;
                  end else begin
                     nxt_state = ST_WINDOW;
                     wakeTmr.load = 1'b1;
                  end
               end
            end
            ST_WAIT_PAGE: begin
               if (wakeArmed && rxdRise) begin
                  nxt_state = ST_WINDOW;
                  nxt_inact = timeout_ff;
                  nxt_dataWake = 1'b1;
                  wakeTmr.load = 1'b1;
               end else if (pagingStrobe || netState != NET_2G) begin
                  nxt_state = ST_WINDOW;
                  wakeTmr.load = 1'b1;
               end
            end
            ST_WINDOW: begin
               if (rxCharStrobe && !dataWake_ff) begin
                  nxt_inact = timeout_ff;
               end else if (!wakeTmr.busy && inact_ff == 16'h0000 &&
                            !txPending) begin
                  nxt_state = ST_DISABLED;
                  sleepTmr.load = 1'b1;
               end
            end
            default: begin
               nxt_state = ST_DISABLED;
            end
         endcase
      end else if (setting_ff == PS_RTS && rtsRise) begin
         wakeTmr.load = 1'b1;
      end else if (setting_ff == PS_DTR && dtrRise) begin
         wakeTmr.load = 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_ff <= ST_DISABLED;
         inact_ff <= 16'h0000;
         dataWake_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         inact_ff <= nxt_inact;
         dataWake_ff <= nxt_dataWake;
      end
   end

   // ******************************
   // Port, idle and handshake outputs
   // ******************************
   logic portOn;
   logic portEnable_ff;
   logic nxt_portEnable;
   logic active_ff;
   logic nxt_active;
   logic cts_n_ff;
   logic nxt_cts_n;
   logic discard_ff;
   logic nxt_discard;

   always_comb begin
      case (setting_ff)
         PS_ALWAYS: portOn = 1'b1;
         PS_CYCLIC: portOn = (state_ff == ST_WINDOW);
         PS_RTS: portOn = rtsOn;
         PS_DTR: portOn = dtrOn;
         default: portOn = 1'b1;
      endcase
      portOn = portOn | txPending;
      nxt_portEnable = portOn;
      if (setting_ff == PS_ALWAYS || usbActive || txPending) begin
         nxt_active = 1'b1;
      end else if ((wakeTmr.busy || wakeTmr.load) && !active_ff) begin
         nxt_active = 1'b0;
      end else begin
         nxt_active = portOn;
      end
      if (hwFlow_ff && setting_ff != PS_ALWAYS) begin
         nxt_cts_n = ~portOn;
      end else begin
         nxt_cts_n = 1'b0;
      end
      nxt_discard = ((setting_ff == PS_RTS) && !rtsOn) ||
                    ((setting_ff == PS_DTR) && !dtrOn) ||
                    (isCyclic && nxt_dataWake) ||
                    (isCyclic && state_ff != ST_WINDOW);
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         portEnable_ff <= 1'b1;
         active_ff <= 1'b1;
         cts_n_ff <= 1'b0;
         discard_ff <= 1'b0;
      end else begin
         portEnable_ff <= nxt_portEnable;
         active_ff <= nxt_active;
         cts_n_ff <= nxt_cts_n;
         discard_ff <= nxt_discard;
      end
   end

   assign portEnable = portEnable_ff;
   assign activeMode = active_ff;
   assign ctsPin_n = cts_n_ff;
   assign rxDiscard = discard_ff;

   // ******************************
   // Register read
   // ******************************
   logic [DATA_W-1:0] rdata_ff;
   logic [DATA_W-1:0] nxt_rdata;

   always_comb begin
      nxt_rdata = '0;
      if (regRead) begin
         case (regAddr)
            REG_CTRL: begin
               nxt_rdata[CTRL_SET_LSB +: 2] = setting_ff;
               nxt_rdata[CTRL_FLOW_BIT] = hwFlow_ff;
            end
            REG_TIMEOUT: nxt_rdata[15:0] = timeout_ff;
            REG_STATUS: begin
               nxt_rdata[STAT_PORT_BIT] = portEnable_ff;
               nxt_rdata[STAT_ACTIVE_BIT] = active_ff;
               nxt_rdata[STAT_REJECT_BIT] = reject_ff;
               nxt_rdata[STAT_WAKE_BIT] = dataWake_ff;
               nxt_rdata[STAT_STATE_LSB +: 2] = state_ff;
            end
            default: nxt_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign regRdata = rdata_ff;

   // ******************************
   // Checks
   // ******************************
   chk_cyclic_off_now: assert property (
      @(posedge core_clk) disable iff (rst)
      (cfgAccept && nxt_setting == PS_CYCLIC) ##1 (!txPending && isCyclic)
      |=> !portEnable_ff)
      else $error("port not disabled after selecting setting 1");

   chk_timeout_range: assert property (
      @(posedge core_clk) disable iff (rst)
      timeout_ff >= TMO_MIN && timeout_ff <= TMO_MAX)
      else $error("inactivity timeout out of range");

   chk_rx_restart: assert property (
      @(posedge core_clk) disable iff (rst)
      (isCyclic && state_ff == ST_WINDOW && rxCharStrobe && !dataWake_ff &&
       !cfgAccept) |=> inact_ff == $past(timeout_ff))
      else $error("received character did not restart inactivity");

   chk_tx_keeps_on: assert property (
      @(posedge core_clk) disable iff (rst)
      txPending |=> portEnable_ff && active_ff)
      else $error("pending transmit did not enable port");

   chk_page_opens: assert property (
      @(posedge core_clk) disable iff (rst)
      (isCyclic && state_ff == ST_WAIT_PAGE && pagingStrobe && !cfgAccept)
      |=> state_ff == ST_WINDOW ##1 portEnable_ff)
      else $error("paging strobe did not open the port");

   chk_cts_follow: assert property (
      @(posedge core_clk) disable iff (rst)
      (hwFlow_ff && setting_ff != PS_ALWAYS && !cfgAccept)
      |=> ctsPin_n == !portEnable_ff)
      else $error("clear-to-send does not follow port enable");

   chk_no_rts_flow: assert property (
      @(posedge core_clk) disable iff (rst)
      !(setting_ff == PS_RTS && hwFlow_ff))
      else $error("setting 2 with flow control accepted");

   chk_rts_off: assert property (
      @(posedge core_clk) disable iff (rst)
      (setting_ff == PS_RTS && !rtsOn && !txPending && !cfgAccept)
      |=> !portEnable_ff && rxDiscard)
      else $error("port enabled with request-to-send off");

   chk_dtr_holds: assert property (
      @(posedge core_clk) disable iff (rst)
      (setting_ff == PS_DTR && dtrOn && !cfgAccept) |=> portEnable_ff)
      else $error("port disabled with terminal-ready on");

   chk_dtr_wake: assert property (
      @(posedge core_clk) disable iff (rst)
      (setting_ff == PS_DTR && dtrRise && !active_ff && !usbActive &&
       !txPending && !cfgAccept) |=> !active_ff)
      else $error("active before wake time elapsed");

   chk_usb_active: assert property (
      @(posedge core_clk) disable iff (rst)
      usbActive |=> active_ff)
      else $error("idle entered with USB link active");

   chk_default_on: assert property (
      @(posedge core_clk) disable iff (rst)
      (setting_ff == PS_ALWAYS && !cfgAccept)
      |=> portEnable_ff && active_ff && !ctsPin_n)
      else $error("setting 0 did not hold port on");

endmodule : ups_power_save

/* File: tb/ups_dte_model.sv */
// Behavioural terminal that drives the control and data pins
module ups_dte_model (
   // Clock
   input wire logic core_clk,
   // Commands from the bench
   input wire logic rtsOn,
   input wire logic dtrOn,
   input wire logic wakeReq,
   // Pins toward the controller
   output logic rtsPin_n,
   output logic dtrPin_n,
   output logic rxdPin
);
   timeunit 1ns;
   timeprecision 100ps;
   int lowCnt = 0;

   initial begin
      rtsPin_n = 1'b0;
      dtrPin_n = 1'b0;
      rxdPin = 1'b1;
   end

   // Lines change only just after a clock edge
   always @(posedge core_clk) begin
      rtsPin_n <= ~rtsOn;
      dtrPin_n <= ~dtrOn;
      // Wake or dummy character: low, then a rising edge back to idle
      if (wakeReq) begin
         lowCnt <= 4;
      end else if (lowCnt > 0) begin
         lowCnt <= lowCnt - 1;
      end
      rxdPin <= !(wakeReq || lowCnt > 1);
   end
endmodule : ups_dte_model

/* File: tb/uart_power_save_control_tb_top.sv */
// Self-checking bench for the serial port power-save controller
`define CHK(n, e, g) cmp(n, 32'(e), 32'(g))
module uart_power_save_control_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import ups_pkg::*;
   logic core_clk, rst, regWrite, regRead, pagingStrobe, usbActive;
   logic [7:0] regAddr;
   logic [31:0] regWdata, regRdata, d;
   logic [1:0] netState;
   logic txPending, rxCharStrobe, portEnable, rxDiscard, activeMode;
   logic rxdPin, rtsPin_n, dtrPin_n, ctsPin_n, rtsOn, dtrOn, wakeReq;
   logic frameTick = 1'b0;
   logic [3:0] frameCnt = 4'h0;
   int failCount = 0;
   int checkCount = 0;
   int ctrlM = 4;
   int tmoM = 2000;
   int tv[6];

   ups_power_save #(.WAKE_CYC(32'd20), .SLEEP_2G_CYC(32'd50),
      .SLEEP_3G_CYC(32'd60)) dut (.core_clk(core_clk), .rst(rst),
      .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
      .regRead(regRead), .regRdata(regRdata), .frameTick(frameTick),
      .pagingStrobe(pagingStrobe), .netState(netState),
      .usbActive(usbActive), .txPending(txPending),
      .rxCharStrobe(rxCharStrobe), .portEnable(portEnable),
      .rxDiscard(rxDiscard), .activeMode(activeMode), .rxdPin(rxdPin),
      .rtsPin_n(rtsPin_n), .dtrPin_n(dtrPin_n), .ctsPin_n(ctsPin_n));

   ups_dte_model dte (.core_clk(core_clk), .rtsOn(rtsOn), .dtrOn(dtrOn),
      .wakeReq(wakeReq), .rtsPin_n(rtsPin_n), .dtrPin_n(dtrPin_n),
      .rxdPin(rxdPin));

   // ******************************
   // Clock and frame tick
   // ******************************
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      frameCnt <= frameCnt + 4'h1;
      frameTick <= (frameCnt == 4'hF);
   end

   // ******************************
   // Tasks
   // ******************************
   task automatic endOfTest;
      $display("checks %0d mismatches %0d", checkCount, failCount);
      if (failCount == 0 && checkCount > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : endOfTest

   task automatic cmp(input string n, input logic [31:0] e,
      input logic [31:0] g);
      checkCount++;
      if (g !== e) begin
         failCount++;
         $display("mismatch %s expected %0h seen %0h", n, e, g);
      end
   endtask : cmp

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   task automatic waitFor(input bit act, input logic v, input int n);
      int i;
      i = 0;
      while (((act ? activeMode : portEnable) !== v) && i < n) begin
         tick(1);
         i++;
      end
      if (i >= n) begin
         failCount++;
         $display("mismatch wait expected %0b seen timeout", v);
         endOfTest();
      end
   endtask : waitFor

   task automatic wr(input logic [7:0] a, input logic [31:0] w);
      @(posedge core_clk);
      regAddr <= a;
      regWdata <= w;
      regWrite <= 1'b1;
      @(posedge core_clk);
      regWrite <= 1'b0;
      if (a == REG_CTRL && !(w[1:0] == PS_RTS && w[2])) begin
         ctrlM = int'(w[2:0]);
      end
      if (a == REG_TIMEOUT) begin
         tmoM = (w[15:0] < 40) ? 40 : (w[15:0] > 65000) ? 65000 : w[15:0];
      end
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      @(posedge core_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1;
      r = regRdata;
   endtask : rd

   task automatic rdChk(input logic [7:0] a);
      logic [31:0] r;
      rd(a, r);
      cmp("regRdata", (a == REG_CTRL) ? ctrlM :
         (a == REG_TIMEOUT) ? tmoM : 0, r);
   endtask : rdChk

   task automatic pulse(input int s);
      @(posedge core_clk);
      wakeReq <= (s == 0);
      rxCharStrobe <= (s == 1);
      pagingStrobe <= (s == 2);
      @(posedge core_clk);
      wakeReq <= 1'b0;
      rxCharStrobe <= 1'b0;
      pagingStrobe <= 1'b0;
   endtask : pulse

   // ******************************
   // Main sequence
   // ******************************
   initial begin
      void'($urandom(30950));
      {rst, rtsOn, dtrOn} = 3'b111;
      {regWrite, regRead, pagingStrobe, usbActive} = 4'h0;
      {txPending, rxCharStrobe, wakeReq} = 3'h0;
      {regAddr, regWdata} = 40'h0;
      netState = NET_3G;
      tv = '{39, 40, 65000, 65001, 0, 0};
      tv[4] = $urandom_range(65535);
      tv[5] = $urandom_range(65535);
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      tick(1);
      `CHK("portEnable", 1, portEnable);
      `CHK("ctsPin_n", 0, ctsPin_n);
      `CHK("activeMode", 1, activeMode);
      rdChk(REG_CTRL);
      rdChk(REG_TIMEOUT);
      rdChk(8'h0C);
      wr(REG_CTRL, 32'h6);
      rdChk(REG_CTRL);
      rd(REG_STATUS, d);
      `CHK("reject", 1, d[STAT_REJECT_BIT]);
      wr(REG_STATUS, 32'h4);
      rd(REG_STATUS, d);
      `CHK("reject", 0, d[STAT_REJECT_BIT]);
      foreach (tv[i]) begin
         wr(REG_TIMEOUT, tv[i]);
         rdChk(REG_TIMEOUT);
      end
      wr(REG_TIMEOUT, 32'd40);
      wr(REG_CTRL, 32'h5);
      tick(1);
      `CHK("portEnable", 0, portEnable);
      `CHK("ctsPin_n", 1, ctsPin_n);
      pulse(0);
      tick(10);
      `CHK("portEnable", 0, portEnable);
      waitFor(0, 1, 80);
      `CHK("ctsPin_n", 0, ctsPin_n);
      waitFor(0, 0, 40);
      `CHK("portEnable", 0, portEnable);
      @(posedge core_clk);
      netState <= NET_NONE;
      waitFor(0, 1, 80);
      `CHK("portEnable", 1, portEnable);
      pulse(1);
      tick(300);
      pulse(1);
      tick(400);
      `CHK("portEnable", 1, portEnable);
      waitFor(0, 0, 700);
      `CHK("portEnable", 0, portEnable);
      @(posedge core_clk);
      txPending <= 1'b1;
      waitFor(0, 1, 5);
      `CHK("activeMode", 1, activeMode);
      @(posedge core_clk);
      txPending <= 1'b0;
      netState <= NET_2G;
      wr(REG_CTRL, 32'h1);
      tick(2);
      pulse(0);
      waitFor(0, 1, 10);
      `CHK("rxDiscard", 1, rxDiscard);
      tick(25);
      `CHK("rxDiscard", 0, rxDiscard);
      waitFor(0, 0, 800);
      tick(70);
      `CHK("portEnable", 0, portEnable);
      pulse(2);
      waitFor(0, 1, 5);
      `CHK("portEnable", 1, portEnable);
      wr(REG_CTRL, 32'h2);
      tick(80);
      `CHK("portEnable", 1, portEnable);
      `CHK("activeMode", 1, activeMode);
      @(posedge core_clk);
      rtsOn <= 1'b0;
      waitFor(0, 0, 8);
      `CHK("rxDiscard", 1, rxDiscard);
      pulse(0);
      tick(10);
      `CHK("portEnable", 0, portEnable);
      @(posedge core_clk);
      txPending <= 1'b1;
      waitFor(0, 1, 5);
      `CHK("portEnable", 1, portEnable);
      @(posedge core_clk);
      txPending <= 1'b0;
      waitFor(0, 0, 5);
      @(posedge core_clk);
      rtsOn <= 1'b1;
      waitFor(0, 1, 8);
      `CHK("activeMode", 0, activeMode);
      waitFor(1, 1, 30);
      `CHK("activeMode", 1, activeMode);
      wr(REG_CTRL, 32'h7);
      tick(3);
      `CHK("portEnable", 1, portEnable);
      `CHK("ctsPin_n", 0, ctsPin_n);
      @(posedge core_clk);
      dtrOn <= 1'b0;
      waitFor(0, 0, 8);
      `CHK("ctsPin_n", 1, ctsPin_n);
      `CHK("rxDiscard", 1, rxDiscard);
      @(posedge core_clk);
      usbActive <= 1'b1;
      tick(3);
      `CHK("activeMode", 1, activeMode);
      `CHK("portEnable", 0, portEnable);
      @(posedge core_clk);
      usbActive <= 1'b0;
      dtrOn <= 1'b1;
      waitFor(0, 1, 8);
      `CHK("activeMode", 0, activeMode);
      waitFor(1, 1, 30);
      `CHK("portEnable", 1, portEnable);
      endOfTest();
   end

   initial begin
      #2000000;
      failCount++;
      $display("mismatch watchdog expected done seen timeout");
      endOfTest();
   end
endmodule : uart_power_save_control_tb_top
